// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ---------------------------------------------------------------
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins in, synced out
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync
);
   logic [W-1:0] meta_r; // First stage, read only by second
   // Two stages; the first is never decoded
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         sync <= RST_VAL;
      end else begin
         meta_r <= pin;
         sync <= meta_r;
      end
   end
endmodule : pin_sync

// >>> rtl/reg_access_if.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Register access between serial front end and bank
// ---------------------------------------------------------------
interface reg_access_if;
   import switch_mon_pkg::*;
   logic rd_stb; // Read request pulse
   logic wr_stb; // Write request pulse
   logic [ADDR_W-1:0] addr; // Register offset
   logic [DATA_W-1:0] wdata; // Write word
   logic [DATA_W-1:0] rdata; // Read word
   modport master (output rd_stb, wr_stb, addr, wdata, input rdata);
   modport slave (input rd_stb, wr_stb, addr, wdata, output rdata);
endinterface : reg_access_if

// >>> rtl/spi_frame_slave.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial frame slave: 32-bit frames, mode 0, MSB first
// ---------------------------------------------------------------
module spi_frame_slave
   import switch_mon_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Synchronised pins in, data out and its enable
   input wire logic sclk_s,
   input wire logic cs_n_s,
   input wire logic sdi_s,
   output logic sdo,
   output logic sdo_oe,
   // Register side
   reg_access_if.master ra
);
   logic sclk_d_r; // Previous clock level
   logic cs_d_r; // Previous select level
   logic [5:0] cnt_r; // Bits taken in this frame
   logic [FRAME_BITS-1:0] sr_r; // Inbound shift register
   logic [DATA_W-1:0] so_r; // Outbound shift register
   wire active = ~cs_n_s;
   wire rise = sclk_s & ~sclk_d_r;
   wire fall = ~sclk_s & sclk_d_r;
   wire cs_end = cs_n_s & ~cs_d_r;
   // Read once the header minus pad is in and flag says read
   assign ra.rd_stb = active & rise & (cnt_r == HDR_LAST) & ~sr_r[HDR_BITS-2];
   // Write only on a complete frame with the write flag
   assign ra.wr_stb = cs_end & (cnt_r == FRAME_LAST) & sr_r[FRAME_BITS-1];
   assign ra.addr = cs_end ? sr_r[FRAME_BITS-2 -: ADDR_W] : sr_r[ADDR_W-1:0];
   assign ra.wdata = sr_r[DATA_W-1:0];
   assign sdo = so_r[DATA_W-1];
   assign sdo_oe = active;
   // Edge history
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         cs_d_r <= cs_n_s;
      end
   end
   // Inbound shifting; extra clocks past the frame are ignored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         sr_r <= '0;
      end else if (cs_n_s) begin
         cnt_r <= '0;
      end else if (rise && cnt_r != FRAME_LAST) begin
         cnt_r <= cnt_r + 6'h01;
         sr_r <= {sr_r[FRAME_BITS-2:0], sdi_s};
      end
   end
   // Outbound word loads on the pad bit, shifts on later falls
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         so_r <= '0;
      end else if (ra.rd_stb) begin
         so_r <= ra.rdata; // R12
      end else if (cs_n_s) begin
         so_r <= '0;
      end else if (fall && cnt_r > HDR_CNT) begin
         so_r <= {so_r[DATA_W-2:0], 1'b0};
      end
   end
endmodule : spi_frame_slave

// >>> rtl/switch_adc_result_config_regs.sv
// Function
// (R1) Input 23 result in bits 19-10
// (R2) Input 22 result in bits 9-0
// (R3) Selftest result in bits 19-10
// (R4) Supply measurement in bits 9-0
// (R5) Result registers read-only, zero reset, reserved zero
// (R6) Bit 23 picks divider three or ten
// (R7) Bit 22 enables converter selftest
// (R8) Bits 21-18 enable wetting checks inputs 3-0
// (R9) Reduction lowers 10/15 mA to 2 mA
// (R10) Configuration read/write, resets to zero
// (R11) Remaining configuration fields at fixed positions
// (R12) Host reaches registers with 24-bit serial words

`timescale 1ns/1ps
module switch_adc_result_config_regs
   import switch_mon_pkg::*;
#(
   parameter int NUM_INPUTS = 24
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,

   // Serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,

   // Converter results with one-cycle valid strobes
   input wire logic [VAL_W-1:0] switch_input_23_value,
   input wire logic in23_valid,
   input wire logic [VAL_W-1:0] switch_input_22_value,
   input wire logic in22_valid,
   input wire logic [VAL_W-1:0] converter_selftest_value,
   input wire logic selftest_valid,
   input wire logic [VAL_W-1:0] supply_measure_value,
   input wire logic supply_valid,

   // Wetting current reduction
   input wire logic wet_reduce_on,
   input wire logic [3*NUM_INPUTS-1:0] wet_setting,
   output logic [3*NUM_INPUTS-1:0] wet_current_eff,

   // Configuration outputs
   output logic supply_divider_select,
   output logic [3:0] supply_divide_factor,
   output logic converter_selftest_on,
   output logic [3:0] wetting_check_on,
   output logic supply_measure_on,
   output logic thermal_current_cut_sink,
   output logic [1:0] debounce_count_sel,
   output logic thermal_current_cut_source,
   output logic int_config,
   output logic trigger,
   output logic poll_en,
   output logic crc_on,
   output logic [4:0] sampling_active_duration,
   output logic [3:0] poll_period
);

   // ---------------------------------------------------------------
   // Pin synchronisers and serial front end
   // ---------------------------------------------------------------
   logic [2:0] pins_s; // Synced clock, select, data
   reg_access_if ra (); // Strobes and words between front end and bank
   // All three pins share one synchroniser, so their relative
   // timing is kept; idle levels are clock low, not selected
   pin_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
      .clk (sys_clk),
      .rst_n (rst_n),
      .pin ({spi_sclk, spi_cs_n, spi_sdi}),
      .sync (pins_s)
   );

   // Frame decode and the outbound shifter; only strobes and
   // words and the offset cross into the bank below
   spi_frame_slave u_spi (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .sclk_s (pins_s[2]),
      .cs_n_s (pins_s[1]),
      .sdi_s (pins_s[0]),
      .sdo (spi_sdo),
      .sdo_oe (spi_sdo_oe),
      .ra (ra.master)
   );

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   // Only the 10-bit result fields are stored; reserved bits are tied
   // to zero in the read words and cost no flip-flops
   logic [VAL_W-1:0] in23_r; // Upper half of pair result
   logic [VAL_W-1:0] in22_r; // Lower half of pair result
   logic [VAL_W-1:0] selftest_r; // Upper half of diag result
   logic [VAL_W-1:0] supply_r; // Lower half of diag result
   // Configuration kept whole, so readback is a plain select
   logic [DATA_W-1:0] cfg_r; // Configuration word

   // ---------------------------------------------------------------
   // Address decode and read mux
   // ---------------------------------------------------------------
   // Full offset compare with no aliases; a stray offset reads
   // zero and a write to it is simply lost
   wire hit_pair = (ra.addr == OFS_PAIR_HIGH);
   wire hit_diag = (ra.addr == OFS_SELFTEST);
   wire hit_cfg = (ra.addr == OFS_CONFIG);
   // Writes reach only the configuration word
   wire cfg_we = ra.wr_stb & hit_cfg;

   // Reserved bits are hard zeros, not storage
   wire [DATA_W-1:0] pair_word = {RSVD_ZERO, in23_r, in22_r}; // R1 R2 R5
   wire [DATA_W-1:0] diag_word = {RSVD_ZERO, selftest_r, supply_r}; // R3 R4 R5

   // Read words are plain selects, ready on the strobe's own edge
   // Unmapped offsets read as zero
   assign ra.rdata = hit_pair ? pair_word : // R12
                     hit_diag ? diag_word :
                     hit_cfg ? cfg_r : RESULT_RST;

   // ---------------------------------------------------------------
   // Result capture; host writes never reach these
   // ---------------------------------------------------------------
   // Values and strobes come from the converter on this clock,
   // so they are used directly with no synchroniser
   // Input pair results follow the converter strobes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in23_r <= '0; // R5
         in22_r <= '0;
      end else begin
         if (in23_valid) begin
            in23_r <= switch_input_23_value; // R1
         end
         if (in22_valid) begin
            in22_r <= switch_input_22_value; // R2
         end
      end
   end

   // Diagnostic results only update while their function is on,
   // so a stale strobe cannot overwrite a meaningful value
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         selftest_r <= '0; // R5
         supply_r <= '0;
      end else begin
         if (selftest_valid && converter_selftest_on) begin
            selftest_r <= converter_selftest_value; // R3 R7
         end
         if (supply_valid && supply_measure_on) begin
            supply_r <= supply_measure_value; // R4
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   // Whole word written at once; every bit is read/write
   // A short or cut frame never raises the write strobe, so a
   // half-shifted word cannot land here
   // Reset leaves every option off or at its zero setting
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= CONFIG_RST; // R10
      end else if (cfg_we) begin
         cfg_r <= ra.wdata; // R10
      end
   end

   // ---------------------------------------------------------------
   // Configuration field outputs
   // ---------------------------------------------------------------
   // Every field but the divide factor is a level straight from the register
   // Supply divider and converter selftest controls
   assign supply_divider_select = cfg_r[CFG_DIV_SEL];
   assign supply_divide_factor = cfg_r[CFG_DIV_SEL] ? DIV_HIGH : DIV_LOW; // R6
   assign converter_selftest_on = cfg_r[CFG_SELFTEST]; // R7

   // Index 3 is bit 21 down to index 0 at bit 18
   assign wetting_check_on = cfg_r[CFG_WET_MSB:CFG_WET_LSB]; // R8

   // Supply, thermal and debounce controls
   assign supply_measure_on = cfg_r[CFG_SUPPLY_ON]; // R11
   assign thermal_current_cut_sink = cfg_r[CFG_THERM_SINK];
   assign debounce_count_sel = cfg_r[CFG_DEB_MSB:CFG_DEB_LSB]; // R11
   assign thermal_current_cut_source = cfg_r[CFG_THERM_SRC];

   // Interrupt, trigger, polling and checksum controls
   assign int_config = cfg_r[CFG_INT_CFG]; // R11
   assign trigger = cfg_r[CFG_TRIGGER];
   assign poll_en = cfg_r[CFG_POLL_EN];
   assign crc_on = cfg_r[CFG_CRC];
   assign sampling_active_duration = cfg_r[CFG_ACT_MSB:CFG_ACT_LSB]; // R11
   assign poll_period = cfg_r[CFG_PER_MSB:0];

   // ---------------------------------------------------------------
   // Wetting current reduction
   // ---------------------------------------------------------------
   // A function, as every input shares the same decode
   // High settings drop to 2 mA; lower settings are untouched
   function automatic logic [2:0] wet_reduce(input logic [2:0] code, input logic en);
      if (en && (code == WET_10MA || code == WET_15MA)) begin
         return WET_2MA;
      end
      return code;
   endfunction : wet_reduce
   logic [3*NUM_INPUTS-1:0] wet_eff_nxt; // Reduced codes before the register
   // One decode per input, all sharing the same enable
   for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_wet
      assign wet_eff_nxt[3*i +: 3] = wet_reduce(wet_setting[3*i +: 3], wet_reduce_on); // R9
   end
   // Registered so the current drivers never see a decode glitch;
   // the price is one cycle of lag after a setting change
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wet_current_eff <= '0; // All inputs at 0 mA
      end else begin
         wet_current_eff <= wet_eff_nxt; // R9
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Every check runs on the system clock and rests during reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Result field placement
   in23_field_a: assert property ( // R1
      in23_valid |=> pair_word[HI_MSB:HI_LSB] == $past(switch_input_23_value))
      else $error("input 23 result not in upper field");

   in22_field_a: assert property ( // R2
      in22_valid |=> pair_word[LO_MSB:0] == $past(switch_input_22_value))
      else $error("input 22 result not in lower field");

   selftest_field_a: assert property ( // R3
      selftest_valid && converter_selftest_on
      |=> diag_word[HI_MSB:HI_LSB] == $past(converter_selftest_value))
      else $error("selftest result not in upper field");

   supply_field_a: assert property ( // R4
      supply_valid && supply_measure_on
      |=> diag_word[LO_MSB:0] == $past(supply_measure_value))
      else $error("supply result not in lower field");

   // Read-only results and reserved bits
   result_ro_a: assert property ( // R5
      ra.wr_stb && (hit_pair || hit_diag) && !in23_valid && !in22_valid
      && !selftest_valid && !supply_valid |=> $stable(pair_word) && $stable(diag_word))
      else $error("host write changed a result register");

   rsvd_zero_a: assert property ( // R5
      (hit_pair || hit_diag) |-> ra.rdata[DATA_W-1:RSVD_LSB] == RSVD_ZERO)
      else $error("reserved result bits not zero");

   // Diagnostic fields hold while their function is off
   selftest_off_a: assert property ( // R7
      !cfg_r[CFG_SELFTEST] ##1 !cfg_r[CFG_SELFTEST] |-> $stable(selftest_r))
      else $error("selftest result moved while disabled");

   supply_off_a: assert property ( // R4
      !supply_measure_on |=> $stable(supply_r))
      else $error("supply result moved while disabled");

   // Configuration decode
   divider_pick_a: assert property ( // R6
      supply_divide_factor == (cfg_r[CFG_DIV_SEL] ? 4'ha : 4'h3))
      else $error("wrong supply divide factor");

   wet_check_a: assert property ( // R8
      wetting_check_on[3] == cfg_r[21] && wetting_check_on[0] == cfg_r[18])
      else $error("wetting check enables misplaced");

   cfg_fields_a: assert property ( // R11
      poll_period == cfg_r[3:0] && sampling_active_duration == cfg_r[8:4]
      && debounce_count_sel == cfg_r[15:14] && poll_en == cfg_r[10])
      else $error("configuration field misplaced");

   // Wetting current reduction, one cycle behind its inputs
   wet_reduce_a: assert property ( // R9
      wet_reduce_on && wet_setting[2:0] inside {WET_10MA, WET_15MA}
      |=> wet_current_eff[2:0] == WET_2MA)
      else $error("wetting current not reduced to 2 mA");

   // Configuration storage and readback
   cfg_write_a: assert property ( // R10
      cfg_we |=> cfg_r == $past(ra.wdata) ##1 ($past(cfg_we) || $stable(cfg_r)))
      else $error("configuration write not held");

   readback_a: assert property ( // R12
      ra.rd_stb && hit_cfg |=> spi_sdo == $past(cfg_r[DATA_W-1]))
      else $error("read word not loaded for shifting");

   // Data out rests low one cycle after select is released
   sdo_idle_a: assert property ( // R12
      !spi_sdo_oe ##1 !spi_sdo_oe |-> !spi_sdo)
      else $error("data out not low while deselected");

   // Main scenarios worth seeing in coverage
   cfg_write_c: cover property (cfg_we);
   pair_read_c: cover property (ra.rd_stb && hit_pair ##[1:1000] ra.rd_stb && hit_diag);
   reduce_c: cover property (wet_reduce_on && wet_setting[2:0] == WET_15MA);
   gated_strobe_c: cover property (selftest_valid && !converter_selftest_on);
   result_write_c: cover property (ra.wr_stb && (hit_pair || hit_diag));
endmodule : switch_adc_result_config_regs

// >>> rtl/switch_mon_pkg.sv
// ---------------------------------------------------------------
// Shared constants for the switch monitor register bank
// ---------------------------------------------------------------
package switch_mon_pkg;
   // Serial frame layout: write flag, address, pad, data
   localparam int DATA_W = 24;
   localparam int ADDR_W = 6;
   localparam int FRAME_BITS = 32;
   localparam int HDR_BITS = 8;
   localparam int VAL_W = 10;
   localparam logic [5:0] FRAME_LAST = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h07;
   localparam logic [5:0] HDR_CNT = 6'h08;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_PAIR_HIGH = 6'h15;
   localparam logic [ADDR_W-1:0] OFS_SELFTEST = 6'h16;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 6'h1a;
   // Reset values
   localparam logic [DATA_W-1:0] RESULT_RST = 24'h000000;
   localparam logic [DATA_W-1:0] CONFIG_RST = 24'h000000;
   localparam logic [3:0] RSVD_ZERO = 4'h0;
   // Result field positions (upper and lower halves)
   localparam int HI_LSB = 10;
   localparam int HI_MSB = 19;
   localparam int LO_MSB = 9;
   localparam int RSVD_LSB = 20;
   // Configuration field positions
   localparam int CFG_DIV_SEL = 23;
   localparam int CFG_SELFTEST = 22;
   localparam int CFG_WET_MSB = 21;
   localparam int CFG_WET_LSB = 18;
   localparam int CFG_SUPPLY_ON = 17;
   localparam int CFG_THERM_SINK = 16;
   localparam int CFG_DEB_MSB = 15;
   localparam int CFG_DEB_LSB = 14;
   localparam int CFG_THERM_SRC = 13;
   localparam int CFG_INT_CFG = 12;
   localparam int CFG_TRIGGER = 11;
   localparam int CFG_POLL_EN = 10;
   localparam int CFG_CRC = 9;
   localparam int CFG_ACT_MSB = 8;
   localparam int CFG_ACT_LSB = 4;
   localparam int CFG_PER_MSB = 3;
   // Supply divider factors
   localparam logic [3:0] DIV_LOW = 4'h3;
   localparam logic [3:0] DIV_HIGH = 4'ha;
   // Wetting current setting codes
   typedef enum logic [2:0] {
      WET_0MA = 3'h0, WET_1MA = 3'h1, WET_2MA = 3'h2,
      WET_5MA = 3'h3, WET_10MA = 3'h4, WET_15MA = 3'h5
   } wet_code_t;
endpackage : switch_mon_pkg

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Host side of the serial link, mode 0
// ---------------------------------------------
module spi_host_model
   import switch_mon_pkg::*;
#(
   parameter int HALF = 8 // sys_clk cycles per sclk level, device needs 3
) (
   // Clock
   input wire logic sys_clk,
   // Serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   // Idle: clock low, not selected
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end

   // One frame of nbits, MSB first; read word gathered on rising edges
   task automatic frame(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                        input int nbits, output logic [DATA_W-1:0] rdata);
      logic [FRAME_BITS-1:0] word;
      word = {wr, addr, 1'b0, data};
      rdata = '0;
      @(negedge sys_clk);
      spi_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_sdi = word[FRAME_BITS-1-i];
         repeat (HALF) @(negedge sys_clk);
         // Sample before the rise, as the device still holds the bit
         if (i >= HDR_BITS) begin
            rdata = {rdata[DATA_W-2:0], spi_sdo};
         end
         spi_sclk = 1'b1;
         repeat (HALF) @(negedge sys_clk);
         spi_sclk = 1'b0;
      end
      repeat (HALF) @(negedge sys_clk);
      spi_cs_n = 1'b1;
      // Released data line must not keep its last level
      spi_sdi = ~spi_sdi;
      repeat (HALF) @(negedge sys_clk);
   endtask : frame
endmodule : spi_host_model

// >>> sim/switch_adc_result_config_regs_test.sv
`timescale 1ns/1ps
module switch_adc_result_config_regs_test;
   import switch_mon_pkg::*;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic sys_clk, rst_n;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [VAL_W-1:0] v23, v22, vself, vsup;
   logic ok23, ok22, okself, oksup;
   logic wet_reduce_on;
   logic [71:0] wet_setting, wet_current_eff;
   logic supply_divider_select, converter_selftest_on, supply_measure_on, thermal_current_cut_sink;
   logic thermal_current_cut_source, int_config, trigger, poll_en, crc_on;
   logic [3:0] supply_divide_factor, wetting_check_on, poll_period;
   logic [1:0] debounce_count_sel;
   logic [4:0] sampling_active_duration;
   logic [DATA_W-1:0] cfg_view; // Config outputs packed back into register order
   int n_errors = 0;
   int checked = 0;

   assign cfg_view = {supply_divider_select, converter_selftest_on, wetting_check_on, supply_measure_on,
                      thermal_current_cut_sink, debounce_count_sel, thermal_current_cut_source, int_config,
                      trigger, poll_en, crc_on, sampling_active_duration, poll_period};

   // ---------------------------------------------
   // Device and host
   // ---------------------------------------------
   switch_adc_result_config_regs #(.NUM_INPUTS(24)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .switch_input_23_value(v23), .in23_valid(ok23),
      .switch_input_22_value(v22), .in22_valid(ok22), .converter_selftest_value(vself),
      .selftest_valid(okself), .supply_measure_value(vsup), .supply_valid(oksup),
      .wet_reduce_on(wet_reduce_on), .wet_setting(wet_setting), .wet_current_eff(wet_current_eff),
      .supply_divider_select(supply_divider_select), .supply_divide_factor(supply_divide_factor),
      .converter_selftest_on(converter_selftest_on), .wetting_check_on(wetting_check_on),
      .supply_measure_on(supply_measure_on), .thermal_current_cut_sink(thermal_current_cut_sink),
      .debounce_count_sel(debounce_count_sel), .thermal_current_cut_source(thermal_current_cut_source),
      .int_config(int_config), .trigger(trigger), .poll_en(poll_en), .crc_on(crc_on),
      .sampling_active_duration(sampling_active_duration), .poll_period(poll_period));

   spi_host_model #(.HALF(8)) host (
      .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Register read over the link, compared at once
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
      logic [DATA_W-1:0] r;
      host.frame(1'b0, a, 24'h000000, 32, r);
      chk(what, 72'(exp), 72'(r));
   endtask : rd

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int nbits);
      logic [DATA_W-1:0] r;
      host.frame(1'b1, a, d, nbits, r);
   endtask : wr

   // One-cycle converter strobes; values stay put afterwards
   task automatic pulse(input logic [3:0] v, input logic [9:0] a, b, c, d);
      @(negedge sys_clk);
      {v23, v22, vself, vsup} = {a, b, c, d};
      {ok23, ok22, okself, oksup} = v;
      @(negedge sys_clk);
      {ok23, ok22, okself, oksup} = 4'h0;
   endtask : pulse

   // Expected effective wetting codes
   function automatic logic [71:0] wet_exp(input logic [71:0] s, input logic red);
      logic [71:0] e;
      e = s;
      for (int i = 0; i < 24; i++) begin
         if (red && (s[3*i+:3] == WET_10MA || s[3*i+:3] == WET_15MA)) e[3*i+:3] = WET_2MA;
      end
      return e;
   endfunction : wet_exp

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      chk("cfg_reset", 72'(CONFIG_RST), 72'(cfg_view));
      chk("factor_reset", 72'(DIV_LOW), 72'(supply_divide_factor));
      chk("sdo_idle", 72'h0, 72'({spi_sdo_oe, spi_sdo}));
      rd(OFS_PAIR_HIGH, RESULT_RST, "pair_high_reset");
      rd(OFS_SELFTEST, RESULT_RST, "selftest_reset");
      rd(OFS_CONFIG, CONFIG_RST, "cfg_read_reset");
   endtask : t_reset

   // Patterns walk every field both ways, frames back to back
   task automatic t_config();
      logic [DATA_W-1:0] pat [5] = '{24'hffffff, 24'ha5a5a5, 24'h5a5a5a, 24'h800000, 24'h000000};
      foreach (pat[k]) begin
         wr(OFS_CONFIG, pat[k], 32);
         chk("cfg_fields", 72'(pat[k]), 72'(cfg_view));
         chk("factor", 72'(pat[k][23] ? DIV_HIGH : DIV_LOW), 72'(supply_divide_factor));
         rd(OFS_CONFIG, pat[k], "cfg_read");
      end
   endtask : t_config

   task automatic t_results();
      wr(OFS_CONFIG, 24'h420000, 32);
      pulse(4'hf, 10'h3ff, 10'h001, 10'h2aa, 10'h155);
      rd(OFS_PAIR_HIGH, 24'h0ffc01, "pair_high");
      rd(OFS_SELFTEST, 24'h0aa955, "selftest");
      // Lone strobe must touch only its own field
      pulse(4'h4, 10'h000, 10'h200, 10'h000, 10'h000);
      rd(OFS_PAIR_HIGH, 24'h0ffe00, "pair_high_one");
   endtask : t_results

   // Writes to result and unmapped places leave everything alone
   task automatic t_readonly();
      wr(OFS_PAIR_HIGH, 24'hffffff, 32);
      wr(OFS_SELFTEST, 24'hffffff, 32);
      wr(6'h3f, 24'hffffff, 32);
      rd(OFS_PAIR_HIGH, 24'h0ffe00, "pair_high_ro");
      rd(OFS_SELFTEST, 24'h0aa955, "selftest_ro");
      rd(6'h3f, 24'h000000, "unmapped");
      rd(OFS_CONFIG, 24'h420000, "cfg_kept");
   endtask : t_readonly

   // Diagnostics off: strobes ignored; short frame dropped
   task automatic t_gating();
      wr(OFS_CONFIG, 24'h000000, 32);
      pulse(4'h3, 10'h000, 10'h200, 10'h111, 10'h222);
      rd(OFS_SELFTEST, 24'h0aa955, "selftest_gated");
      wr(OFS_CONFIG, 24'h123456, 16);
      chk("cfg_short", 72'h0, 72'(cfg_view));
   endtask : t_gating

   task automatic t_wet();
      @(negedge sys_clk);
      // Input 0 starts on the 15 mA code so the reduction is seen there
      for (int i = 0; i < 24; i++) wet_setting[3*i+:3] = 3'((i + 5) % 6);
      for (int r = 0; r < 2; r++) begin
         wet_reduce_on = r[0];
         @(negedge sys_clk);
         chk("wet_eff", wet_exp(wet_setting, r[0]), wet_current_eff);
      end
   endtask : t_wet

   // ---------------------------------------------
   // Verdict, clock, main sequence, watchdog
   // ---------------------------------------------
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      rst_n = 1'b0;
      {v23, v22, vself, vsup} = '0;
      {ok23, ok22, okself, oksup} = 4'h0;
      wet_reduce_on = 1'b0;
      wet_setting = '0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_reset();
      t_config();
      t_results();
      t_readonly();
      t_gating();
      t_wet();
      give_verdict();
   end

   // About 30 frames of some 530 cycles each fit well inside this
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end
endmodule : switch_adc_result_config_regs_test
